/* logic/rpt_regs.sv */
// Functional notes
// - pin code 0 wait signal, 1 access end/frame sync, 2 modulation/carrier detect.
// - code 3 takes sync input when choice bit 0, else preamble detect out.
// - code 4 wake/wait, 5 demod input/AGC bit 0, 6 SPI data out.
// - code 11 in direct mode disables internal frame sync; pin feeds it.
// - codes 12 valid packet, 13 FIFO pointer, 14 battery, 15 FIFO RX input.
// - invert bit passes selected signal or its inverse.
// - output enable 0 leaves pin undriven, 1 drives it except when the code makes the pin an input.
// - strobe select bit picks register or strobe-command state control.
// - with wake enabled, mode bit picks wake-on-transmit or wake-on-receive.
// - FIFO length bit picks fixed or unbounded length.
// - read-frequency bit returns offset only with compensation active.
// - carrier detect count codes give 16, 32, 64, 128.
// - six bits form upper end pointer over external low byte.
// - calibration fail flag reads 0 pass, 1 fail.
// - VCO current reads auto result or manual value per select bit.
// - VCO current setting is 8 unless switch set, then manual value.
// - auto-IF enable plus 15-bit IF offset over two registers.
// - 16-bit LO offset word over two registers.
// - carrier detect range codes give 8, 16, 24, 32.
// - sync detect type bit picks re-preamble or buffer search.
// - resend done flag is 0 while resending, 1 when finished.
// - valid packet flag sets on event, clears only by strobe command.
// - resend count loads configured cycles, decrements per resend.
`timescale 1ns/100ps
`include "rpt_regs_map.svh"

module rpt_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // radio status sources
  input  wire logic        txMode,
  input  wire logic        directMode,
  input  wire logic        transferFinishedWait,
  input  wire logic        endOfAccessCode,
  input  wire logic        frameSync,
  input  wire logic        txModulationEnable,
  input  wire logic        carrierDetectOut,
  input  wire logic        preambleDetectOut,
  input  wire logic        mcuWakeSignal,
  input  wire logic        waitTransferIndication,
  input  wire logic        quadratureDemodInput,
  input  wire logic        agcLevelBit0,
  input  wire logic        spiDataOut,
  input  wire logic        fifoPointerFlag,
  input  wire logic        batteryDetectFlag,
  // calibration and resend events
  input  wire logic        vcoCalDone,
  input  wire logic        vcoCalFail,
  input  wire logic [3:0]  vcoCalResult,
  input  wire logic [3:0]  resendCycleSetting,
  input  wire logic        resendStart,
  input  wire logic        resendStep,
  input  wire logic        resendFinish,
  input  wire logic        validPacketEvent,
  input  wire logic        strobeClear,
  input  wire logic [7:0]  fifoEndLow,
  // second radio pin
  input  wire logic        pin2In,
  output logic             pin2Out,
  output logic             pin2Oe,
  // pin-derived inputs to the radio
  output logic             extSyncIn,
  output logic             extFrameSync,
  output logic             internalFrameSyncOff,
  output logic             fifoModeRxInput,
  // radio configuration
  output logic             strobeControlSelect,
  output logic             wakeOnTx,
  output logic             wakeOnRx,
  output logic             unboundedLengthSelect,
  output logic             readFreqOffset,
  output logic      [7:0]  carrierDetectCount,
  output logic      [5:0]  carrierDetectRange,
  output logic      [13:0] fifoEndPointer,
  output logic      [3:0]  vcoCurrentSetting,
  output logic             vcoManualSelect,
  output logic      [3:0]  lowGroupFraction,
  output logic      [7:0]  lowGroupInteger,
  output logic      [3:0]  highGroupFraction,
  output logic      [7:0]  highGroupInteger,
  output logic             autoIfEnable,
  output logic      [14:0] ifOffsetWord,
  output logic      [15:0] loOffsetWord,
  output logic             syncDetectType,
  output logic             validPacketFlag,
  output logic             resendDoneFlag,
  output logic      [3:0]  resendCountRemaining
);

  function automatic logic isIdx(input rpt_pkg::rpt_index_t idx,
                                 input rpt_pkg::rpt_index_t want);
    isIdx = (idx == want);
  endfunction : isIdx

  // stored bytes
  rpt_pkg::rpt_byte_t second_pin_function_r, pin_and_mode_control_r, legacy_irq_clock_out_control_r, carrier_count_fifo_end_vco_status_r, vco_current_calibration_control_r;
  rpt_pkg::rpt_byte_t low_group_fraction_r, low_group_integer_r, high_group_fraction_r, high_group_integer_r;
  rpt_pkg::rpt_byte_t if1_r, if2_r, if3_r, if4_r, carrier_sync_and_resend_status_r, aux_r;
  logic               ack_r, err_r;
  logic [31:0]        dat_r;
  logic               vco_current_cal_fail_r;
  logic [3:0]         calVal_r;
  logic               valid_packet_or_ack_ok_r, resendDone_r;
  logic [3:0]         resendCnt_r;
  logic               pinS1_r, pinS2_r, pinOut_r, pinOe_r;

  // bus decode
  wire rpt_pkg::rpt_index_t busIdx = adr_i[15:2];
  wire        busReq   = cyc_i & stb_i & ~ack_r & ~err_r;
  wire        hitAny   = (adr_i[1:0] == 2'b00) &
                         ((busIdx >= `RPT_IDX_SECOND_PIN_FUNCTION && busIdx <= `RPT_IDX_CARRIER_SYNC_AND_RESEND_STATUS) ||
                          isIdx(busIdx, `RPT_IDX_AUX));
  wire        wrStrobe = ack_r & cyc_i & stb_i & we_i & sel_i[0];
  wire [7:0]  wrByte   = dat_i[7:0];

  // own control bits
  wire        syncPreambleChoice = aux_r[0];
  wire        calibrationSwitch  = aux_r[1];
  wire        wakeFunctionEnable = aux_r[2];
  wire        autoFreqComp       = aux_r[3];

  // read layouts; write-only bytes read zero
  wire [3:0]  vcoCurrentValue = vco_current_calibration_control_r[0] ? vco_current_calibration_control_r[4:1] : calVal_r;
  wire [7:0]  vcbRead  = {3'b000, vco_current_cal_fail_r, vcoCurrentValue};
  wire [7:0]  chg1Read = {4'h0, low_group_fraction_r[3:0]};
  wire [7:0]  ack1Read = {2'b00, resendDone_r, valid_packet_or_ack_ok_r, resendCnt_r};
  wire [7:0]  readByte =
    isIdx(busIdx, `RPT_IDX_CARRIER_COUNT_FIFO_END_VCO_STATUS) ? vcbRead :
    isIdx(busIdx, `RPT_IDX_LOW_GROUP_FRACTION) ? chg1Read :
    isIdx(busIdx, `RPT_IDX_LOW_GROUP_INTEGER) ? low_group_integer_r :
    isIdx(busIdx, `RPT_IDX_HIGH_GROUP_FRACTION) ? high_group_fraction_r :
    isIdx(busIdx, `RPT_IDX_HIGH_GROUP_INTEGER) ? high_group_integer_r :
    isIdx(busIdx, `RPT_IDX_IF1)  ? if1_r :
    isIdx(busIdx, `RPT_IDX_IF2)  ? if2_r :
    isIdx(busIdx, `RPT_IDX_CARRIER_SYNC_AND_RESEND_STATUS) ? ack1Read :
    isIdx(busIdx, `RPT_IDX_AUX)  ? aux_r : `RPT_RESET_BYTE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= busReq & hitAny;
      err_r <= busReq & ~hitAny;
      dat_r <= (busReq & hitAny) ? {24'h00_0000, readByte} : 32'h0000_0000;
    end
  end

  assign ack_o = ack_r;
  assign err_o = err_r;
  assign dat_o = dat_r;

  // writes land on the acknowledge edge only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      second_pin_function_r <= `RPT_RESET_BYTE;
      pin_and_mode_control_r  <= `RPT_RESET_BYTE;
      legacy_irq_clock_out_control_r  <= `RPT_RESET_BYTE;
      carrier_count_fifo_end_vco_status_r  <= `RPT_RESET_BYTE;
      vco_current_calibration_control_r  <= `RPT_RESET_BYTE;
      low_group_fraction_r  <= `RPT_RESET_BYTE;
      low_group_integer_r  <= `RPT_RESET_BYTE;
      high_group_fraction_r  <= `RPT_RESET_BYTE;
      high_group_integer_r  <= `RPT_RESET_BYTE;
      if1_r   <= `RPT_RESET_BYTE;
      if2_r   <= `RPT_RESET_BYTE;
      if3_r   <= `RPT_RESET_BYTE;
      if4_r   <= `RPT_RESET_BYTE;
      carrier_sync_and_resend_status_r  <= `RPT_RESET_BYTE;
      aux_r   <= `RPT_RESET_BYTE;
    end else if (wrStrobe) begin
      // status fields at mixed addresses are never written
      if (isIdx(busIdx, `RPT_IDX_SECOND_PIN_FUNCTION)) second_pin_function_r <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_PIN_AND_MODE_CONTROL))  pin_and_mode_control_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_LEGACY_IRQ_CLOCK_OUT_CONTROL))  legacy_irq_clock_out_control_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_CARRIER_COUNT_FIFO_END_VCO_STATUS))  carrier_count_fifo_end_vco_status_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_VCO_CURRENT_CALIBRATION_CONTROL))  vco_current_calibration_control_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_LOW_GROUP_FRACTION))  low_group_fraction_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_LOW_GROUP_INTEGER))  low_group_integer_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_HIGH_GROUP_FRACTION))  high_group_fraction_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_HIGH_GROUP_INTEGER))  high_group_integer_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_IF1))   if1_r   <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_IF2))   if2_r   <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_IF3))   if3_r   <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_IF4))   if4_r   <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_CARRIER_SYNC_AND_RESEND_STATUS))  carrier_sync_and_resend_status_r  <= wrByte;
      if (isIdx(busIdx, `RPT_IDX_AUX))   aux_r   <= wrByte;
    end
  end

  // calibration result and resend status
  wire [3:0] resendDec = (resendCnt_r != 4'h0) ? resendCnt_r - 4'h1 : 4'h0;
  wire [3:0] resendCnt_nxt = resendStart ? resendCycleSetting :
                             resendStep  ? resendDec : resendCnt_r;
  wire       resendDone_nxt = resendFinish | (resendDone_r & ~resendStart);
  wire       valid_packet_or_ack_ok_nxt = validPacketEvent | (valid_packet_or_ack_ok_r & ~strobeClear);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vco_current_cal_fail_r       <= 1'b0;
      calVal_r     <= 4'h0;
      resendCnt_r  <= 4'h0;
      resendDone_r <= 1'b0;
      valid_packet_or_ack_ok_r      <= 1'b0;
    end else begin
      if (vcoCalDone) begin
        vco_current_cal_fail_r   <= vcoCalFail;
        calVal_r <= vcoCalResult;
      end
      resendCnt_r  <= resendCnt_nxt;
      resendDone_r <= resendDone_nxt;
      valid_packet_or_ack_ok_r      <= valid_packet_or_ack_ok_nxt;
    end
  end

  // second radio pin
  wire rpt_pkg::rpt_pinsel_t pinSel = second_pin_function_r[5:2];
  wire        pinInvert = second_pin_function_r[1];
  wire        pinEnable = second_pin_function_r[0];
  wire        pinS      = pinS2_r;
  // selection per code; direct-mode codes 7..10 idle low here
  wire [15:0] pinSrc = {
    1'b0,
    batteryDetectFlag,
    fifoPointerFlag,
    valid_packet_or_ack_ok_r,
    1'b0,
    4'h0,
    spiDataOut,
    directMode ? quadratureDemodInput : agcLevelBit0,
    wakeFunctionEnable ? mcuWakeSignal : waitTransferIndication,
    syncPreambleChoice & preambleDetectOut,
    txMode ? txModulationEnable : carrierDetectOut,
    txMode ? endOfAccessCode : frameSync,
    transferFinishedWait
  };
  wire        pinIsInput = (pinSel == `RPT_SEL_SYNCIN & ~syncPreambleChoice) |
                           (pinSel == `RPT_SEL_FSYNCIN) |
                           (pinSel == `RPT_SEL_FIFORX);
  wire        pinOut_nxt = pinSrc[pinSel] ^ pinInvert;
  wire        pinOe_nxt  = pinEnable & ~pinIsInput;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinS1_r  <= 1'b0;
      pinS2_r  <= 1'b0;
      pinOut_r <= 1'b0;
      pinOe_r  <= 1'b0;
    end else begin
      pinS1_r  <= pin2In;
      pinS2_r  <= pinS1_r;
      pinOut_r <= pinOut_nxt;
      pinOe_r  <= pinOe_nxt;
    end
  end

  assign pin2Out = pinOut_r;
  assign pin2Oe  = pinOe_r;
  // software is expected to keep the choice bit at 1
  assign extSyncIn = (pinSel == `RPT_SEL_SYNCIN) & ~syncPreambleChoice & pinS;
  assign internalFrameSyncOff = (pinSel == `RPT_SEL_FSYNCIN) & directMode;
  assign extFrameSync = internalFrameSyncOff & pinS;
  assign fifoModeRxInput = (pinSel == `RPT_SEL_FIFORX) & pinS;

  // configuration outputs
  assign strobeControlSelect   = pin_and_mode_control_r[3];
  assign wakeOnTx              = wakeFunctionEnable & pin_and_mode_control_r[2];
  assign wakeOnRx              = wakeFunctionEnable & ~pin_and_mode_control_r[2];
  assign unboundedLengthSelect = pin_and_mode_control_r[1];
  assign readFreqOffset        = autoFreqComp & pin_and_mode_control_r[4];
  assign carrierDetectCount    = `RPT_CD_COUNT_BASE << carrier_count_fifo_end_vco_status_r[7:6];
  assign carrierDetectRange    = `RPT_CD_RANGE_STEP * {4'h0, carrier_sync_and_resend_status_r[2:1]} +
                                 `RPT_CD_RANGE_STEP;
  assign fifoEndPointer        = {carrier_count_fifo_end_vco_status_r[5:0], fifoEndLow};
  assign vcoCurrentSetting     = calibrationSwitch ? vco_current_calibration_control_r[4:1] : `RPT_VCO_DEFAULT;
  assign vcoManualSelect       = vco_current_calibration_control_r[0];
  assign lowGroupFraction      = low_group_fraction_r[3:0];
  assign lowGroupInteger       = low_group_integer_r;
  assign highGroupFraction     = high_group_fraction_r[3:0];
  assign highGroupInteger      = high_group_integer_r;
  assign autoIfEnable          = if1_r[7];
  assign ifOffsetWord          = {if1_r[6:0], if2_r};
  assign loOffsetWord          = {if3_r, if4_r};
  assign syncDetectType        = carrier_sync_and_resend_status_r[0];
  assign validPacketFlag       = valid_packet_or_ack_ok_r;
  assign resendDoneFlag        = resendDone_r;
  assign resendCountRemaining  = resendCnt_r;

  // checks
  a_pin_invert_out: assert property (@(posedge clk) disable iff (sys_rst)
    1'b1 |=> pin2Out == ($past(pinSrc[pinSel]) ^ $past(pinInvert)))
    else $error("pin output does not follow selection and invert");
  a_pin_oe_off: assert property (@(posedge clk) disable iff (sys_rst)
    !pinEnable |=> !pin2Oe)
    else $error("pin driven while enable is clear");
  a_valid_packet_or_ack_ok_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    validPacketEvent |=> validPacketFlag)
    else $error("valid packet event lost");
  a_valid_packet_or_ack_ok_hold: assert property (@(posedge clk) disable iff (sys_rst)
    validPacketFlag && !strobeClear |=> validPacketFlag)
    else $error("valid packet flag cleared without strobe");
  a_resend_load: assert property (@(posedge clk) disable iff (sys_rst)
    resendStart |=> resendCountRemaining == $past(resendCycleSetting))
    else $error("resend count not loaded");
  a_resend_done: assert property (@(posedge clk) disable iff (sys_rst)
    resendStart && !resendFinish |=> !resendDoneFlag)
    else $error("resend done flag set while resending");
  a_vco_default: assert property (@(posedge clk) disable iff (sys_rst)
    !calibrationSwitch |-> vcoCurrentSetting == 4'h8)
    else $error("vco current not default with switch clear");
  a_cal_flag: assert property (@(posedge clk) disable iff (sys_rst)
    vcoCalDone |=> vco_current_cal_fail_r == $past(vcoCalFail))
    else $error("calibration flag not captured");
  a_bus_ack_once: assert property (@(posedge clk) disable iff (sys_rst)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_frame_sync_disable: assert property (@(posedge clk) disable iff (sys_rst)
    internalFrameSyncOff |-> directMode ##1 !pin2Oe)
    else $error("frame sync disabled outside direct mode");

endmodule : rpt_regs

/* logic/rpt_regs_map.svh */
`ifndef RPT_REGS_MAP_SVH
`define RPT_REGS_MAP_SVH
// register indices; byte address is four times the index
`define RPT_IDX_SECOND_PIN_FUNCTION      14'h1031
`define RPT_IDX_PIN_AND_MODE_CONTROL       14'h1032
`define RPT_IDX_LEGACY_IRQ_CLOCK_OUT_CONTROL       14'h1033
`define RPT_IDX_CARRIER_COUNT_FIFO_END_VCO_STATUS       14'h1034
`define RPT_IDX_VCO_CURRENT_CALIBRATION_CONTROL       14'h1035
`define RPT_IDX_LOW_GROUP_FRACTION       14'h1036
`define RPT_IDX_LOW_GROUP_INTEGER       14'h1037
`define RPT_IDX_HIGH_GROUP_FRACTION       14'h1038
`define RPT_IDX_HIGH_GROUP_INTEGER       14'h1039
`define RPT_IDX_IF1        14'h103a
`define RPT_IDX_IF2        14'h103b
`define RPT_IDX_IF3        14'h103c
`define RPT_IDX_IF4        14'h103d
`define RPT_IDX_CARRIER_SYNC_AND_RESEND_STATUS       14'h103e
`define RPT_IDX_AUX        14'h10f0
`define RPT_RESET_BYTE     8'h00
// pin function codes
`define RPT_SEL_WAIT       4'h0
`define RPT_SEL_SYNCIN     4'h3
`define RPT_SEL_FSYNCIN    4'hb
`define RPT_SEL_FIFORX     4'hf
// fixed values
`define RPT_VCO_DEFAULT    4'h8
`define RPT_CD_COUNT_BASE  8'h10
`define RPT_CD_RANGE_STEP  6'h08
`endif

/* logic/rpt_pkg.sv */
package rpt_pkg;
  typedef logic [7:0] rpt_byte_t;
  typedef logic [3:0] rpt_pinsel_t;
  typedef logic [13:0] rpt_index_t;
endpackage : rpt_pkg

/* test/rpt_host_model.sv */
`timescale 1ns/100ps

// host side of the second radio pin
module rpt_host_model (
  // clock
  input  wire logic clk,
  // device side of the pin
  input  wire logic pin2Out,
  input  wire logic pin2Oe,
  // host intent
  input  wire logic mcuDrive,
  input  wire logic mcuLevel,
  // resolved wire
  output logic      pinLevel
);
  // undriven wire has no pull: toggle so a stale level never looks valid
  logic toggle_r = 1'b0;

  always_ff @(posedge clk) begin
    toggle_r <= ~toggle_r;
  end

  // host feeds frame sync or rx data when the device lets go
  assign pinLevel = pin2Oe ? pin2Out : (mcuDrive ? mcuLevel : toggle_r);
endmodule : rpt_host_model

/* test/tb_top.sv */
`timescale 1ns/100ps
`include "rpt_regs_map.svh"

module tb_top;
  logic clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'hf, vcoCalResult = 4'h0, resendCycleSetting = 4'h0;
  logic [31:0] dat = 32'h0, datO;
  logic ack, err, txMode = 1'b1, directMode = 1'b0, vcoCalFail = 1'b0;
  logic [12:0] src = 13'h0;
  logic [5:0] ev = 6'h00;
  logic [7:0] fifoEndLow = 8'h9c, cdCount, lgi, hgi;
  logic mcuDrive = 1'b0, mcuLevel = 1'b0, pinLevel, pin2Out, pin2Oe, extSyncIn, extFrameSync;
  logic fsOff, fmRx, scs, wTx, wRx, uls, rfo, vms, auto_if_enable, sdt, vpf, rdf;
  logic [5:0] cdRange;
  logic [13:0] fifo_end_pointer;
  logic [3:0] vcs, lgf, hgf, resend_count_remaining;
  logic [14:0] ifo;
  logic [15:0] lo;
  int error_cnt = 0, n_compared = 0;
  int codes[9] = '{0, 1, 2, 3, 4, 5, 6, 13, 14};
  int idxs[9] = '{0, 1, 3, 5, 7, 9, 10, 11, 12};
  int codesRx[4] = '{1, 2, 4, 5};
  int idxsRx[4] = '{2, 4, 6, 8};
  rpt_pkg::rpt_index_t rwIx[5] = '{`RPT_IDX_LOW_GROUP_INTEGER, `RPT_IDX_HIGH_GROUP_FRACTION, `RPT_IDX_HIGH_GROUP_INTEGER, `RPT_IDX_IF1,
                                   `RPT_IDX_IF2};
  rpt_pkg::rpt_byte_t rwVal[5] = '{8'ha5, 8'h3c, 8'h5a, 8'hc4, 8'h21};

  always #4 clk = ~clk;

  rpt_host_model i_host (.clk(clk), .pin2Out(pin2Out), .pin2Oe(pin2Oe), .mcuDrive(mcuDrive),
                         .mcuLevel(mcuLevel), .pinLevel(pinLevel));

  rpt_regs i_dut (.clk(clk), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(datO), .ack_o(ack), .err_o(err), .txMode(txMode),
    .directMode(directMode), .transferFinishedWait(src[0]), .endOfAccessCode(src[1]),
    .frameSync(src[2]), .txModulationEnable(src[3]), .carrierDetectOut(src[4]),
    .preambleDetectOut(src[5]), .mcuWakeSignal(src[6]), .waitTransferIndication(src[7]),
    .quadratureDemodInput(src[8]), .agcLevelBit0(src[9]), .spiDataOut(src[10]),
    .fifoPointerFlag(src[11]), .batteryDetectFlag(src[12]), .vcoCalDone(ev[0]),
    .vcoCalFail(vcoCalFail), .vcoCalResult(vcoCalResult), .resendCycleSetting(resendCycleSetting),
    .resendStart(ev[1]), .resendStep(ev[2]), .resendFinish(ev[3]), .validPacketEvent(ev[4]),
    .strobeClear(ev[5]), .fifoEndLow(fifoEndLow), .pin2In(pinLevel), .pin2Out(pin2Out),
    .pin2Oe(pin2Oe), .extSyncIn(extSyncIn), .extFrameSync(extFrameSync),
    .internalFrameSyncOff(fsOff), .fifoModeRxInput(fmRx), .strobeControlSelect(scs),
    .wakeOnTx(wTx), .wakeOnRx(wRx), .unboundedLengthSelect(uls), .readFreqOffset(rfo),
    .carrierDetectCount(cdCount), .carrierDetectRange(cdRange), .fifoEndPointer(fifo_end_pointer),
    .vcoCurrentSetting(vcs), .vcoManualSelect(vms), .lowGroupFraction(lgf),
    .lowGroupInteger(lgi), .highGroupFraction(hgf), .highGroupInteger(hgi),
    .autoIfEnable(auto_if_enable), .ifOffsetWord(ifo), .loOffsetWord(lo), .syncDetectType(sdt),
    .validPacketFlag(vpf), .resendDoneFlag(rdf), .resendCountRemaining(resend_count_remaining));

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  // classic single cycle; holds everything until ack or err is sampled
  task automatic wb(input logic w, input rpt_pkg::rpt_index_t ix, input rpt_pkg::rpt_byte_t d,
                    output rpt_pkg::rpt_byte_t q, output logic e);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {ix, 2'b00}; dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(ack | err) && n < 50);
    q = datO[7:0];
    e = err;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 50) chk(n, 0);
  endtask : wb

  task automatic wr(input rpt_pkg::rpt_index_t ix, input rpt_pkg::rpt_byte_t d);
    rpt_pkg::rpt_byte_t q;
    logic e;
    wb(1'b1, ix, d, q, e);
    @(posedge clk);
  endtask : wr

  task automatic rdc(input rpt_pkg::rpt_index_t ix, input rpt_pkg::rpt_byte_t exp);
    rpt_pkg::rpt_byte_t q;
    logic e;
    wb(1'b0, ix, 8'h00, q, e);
    chk(q, exp);
  endtask : rdc

  task automatic pulse(input int b);
    @(posedge clk) ev[b] <= 1'b1;
    @(posedge clk) ev[b] <= 1'b0;
    @(posedge clk);
  endtask : pulse

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc

  initial begin
    rpt_pkg::rpt_byte_t q;
    logic e;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(cdCount, 8'h10);
    chk(cdRange, 6'h08);
    chk(vcs, 4'h8);
    chk(pin2Oe, 1'b0);
    for (int i = 0; i < 5; i++) wr(rwIx[i], rwVal[i]);
    for (int i = 0; i < 5; i++) rdc(rwIx[i], rwVal[i]);
    chk({lgi, hgf, hgi}, {8'ha5, 4'hc, 8'h5a});
    chk({auto_if_enable, ifo}, {1'b1, 15'h4421});
    wr(`RPT_IDX_LOW_GROUP_FRACTION, 8'hb7);
    rdc(`RPT_IDX_LOW_GROUP_FRACTION, 8'h07);
    chk(lgf, 4'h7);
    wr(`RPT_IDX_IF3, 8'h12);
    wr(`RPT_IDX_IF4, 8'h34);
    chk(lo, 16'h1234);
    rdc(`RPT_IDX_IF3, 8'h00);
    wb(1'b1, 14'h0fff, 8'h55, q, e);
    chk(e, 1'b1);
    wr(`RPT_IDX_AUX, 8'h0d);
    wr(`RPT_IDX_PIN_AND_MODE_CONTROL, 8'h1e);
    chk({scs, wTx, wRx, uls, rfo}, 5'b11011);
    wr(`RPT_IDX_PIN_AND_MODE_CONTROL, 8'h00);
    chk({scs, wTx, wRx, uls, rfo}, 5'b00100);
    for (int c = 0; c < 4; c++) begin
      wr(`RPT_IDX_CARRIER_COUNT_FIFO_END_VCO_STATUS, {c[1:0], 6'h2b});
      chk(cdCount, 8'h10 << c);
      chk(fifo_end_pointer, {6'h2b, 8'h9c});
      wr(`RPT_IDX_CARRIER_SYNC_AND_RESEND_STATUS, {5'h00, c[1:0], c[0]});
      chk({sdt, cdRange}, {c[0], 6'((c + 1) * 8)});
    end
    rdc(`RPT_IDX_CARRIER_COUNT_FIFO_END_VCO_STATUS, 8'h00);
    vcoCalFail <= 1'b1;
    vcoCalResult <= 4'h5;
    pulse(0);
    rdc(`RPT_IDX_CARRIER_COUNT_FIFO_END_VCO_STATUS, 8'h15);
    wr(`RPT_IDX_VCO_CURRENT_CALIBRATION_CONTROL, 8'h05);
    rdc(`RPT_IDX_CARRIER_COUNT_FIFO_END_VCO_STATUS, 8'h12);
    chk({vms, vcs}, {1'b1, 4'h8});
    wr(`RPT_IDX_AUX, 8'h0f);
    chk(vcs, 4'h2);
    wr(`RPT_IDX_VCO_CURRENT_CALIBRATION_CONTROL, 8'h04);
    vcoCalFail <= 1'b0;
    vcoCalResult <= 4'h9;
    pulse(0);
    rdc(`RPT_IDX_CARRIER_COUNT_FIFO_END_VCO_STATUS, 8'h09);
    wr(`RPT_IDX_AUX, 8'h01);
    for (int i = 0; i < 9; i++) begin
      src <= 13'h1 << idxs[i];
      wr(`RPT_IDX_SECOND_PIN_FUNCTION, {2'b00, 4'(codes[i]), 2'b01});
      waitc(3);
      chk({pin2Oe, pin2Out}, 2'b11);
      src <= ~(13'h1 << idxs[i]);
      waitc(3);
      chk({pin2Oe, pin2Out}, 2'b10);
    end
    // receive side of the shared codes, wake and direct mode on
    txMode <= 1'b0;
    directMode <= 1'b1;
    wr(`RPT_IDX_AUX, 8'h05);
    for (int i = 0; i < 4; i++) begin
      src <= 13'h1 << idxsRx[i];
      wr(`RPT_IDX_SECOND_PIN_FUNCTION, {2'b00, 4'(codesRx[i]), 2'b01});
      waitc(3);
      chk({pin2Oe, pin2Out}, 2'b11);
      src <= ~(13'h1 << idxsRx[i]);
      waitc(3);
      chk({pin2Oe, pin2Out}, 2'b10);
    end
    txMode <= 1'b1;
    directMode <= 1'b0;
    wr(`RPT_IDX_AUX, 8'h01);
    src <= 13'h1fff;
    wr(`RPT_IDX_SECOND_PIN_FUNCTION, 8'h03);
    waitc(3);
    chk(pin2Out, 1'b0);
    wr(`RPT_IDX_SECOND_PIN_FUNCTION, 8'h02);
    waitc(3);
    chk(pin2Oe, 1'b0);
    wr(`RPT_IDX_SECOND_PIN_FUNCTION, 8'h31);
    pulse(4);
    waitc(2);
    chk({vpf, pin2Out}, 2'b11);
    pulse(5);
    waitc(2);
    chk({vpf, pin2Out}, 2'b00);
    directMode <= 1'b1;
    mcuDrive <= 1'b1;
    mcuLevel <= 1'b1;
    wr(`RPT_IDX_SECOND_PIN_FUNCTION, 8'h2d);
    waitc(4);
    chk({pin2Oe, fsOff, extFrameSync}, 3'b011);
    mcuLevel <= 1'b0;
    waitc(4);
    chk(extFrameSync, 1'b0);
    wr(`RPT_IDX_SECOND_PIN_FUNCTION, 8'h3d);
    mcuLevel <= 1'b1;
    waitc(4);
    chk({pin2Oe, fmRx}, 2'b01);
    wr(`RPT_IDX_AUX, 8'h00);
    wr(`RPT_IDX_SECOND_PIN_FUNCTION, 8'h0d);
    waitc(4);
    chk({pin2Oe, extSyncIn}, 2'b01);
    wr(`RPT_IDX_AUX, 8'h01);
    resendCycleSetting <= 4'h3;
    pulse(1);
    chk({rdf, resend_count_remaining}, 5'h03);
    pulse(2);
    chk(resend_count_remaining, 4'h2);
    pulse(3);
    pulse(4);
    chk(rdf, 1'b1);
    rdc(`RPT_IDX_CARRIER_SYNC_AND_RESEND_STATUS, 8'h32);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule : tb_top
